// >>> rtl/wasc_pkg.sv
package wasc_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE1 = 8'h10;
  localparam logic [7:0] OFS_WAKE2 = 8'h14;
  localparam logic [7:0] OFS_AWAKE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DWELL_LSB = 16;
  localparam int DWELL_W = 5;
  localparam int TILE_GATE_BIT = 14;
  localparam int ANA_PFM_BIT = 9;
  localparam int CORE_PFM_BIT = 8;
  localparam int IO_EN_BIT = 5;
  localparam int PLL_EN_BIT = 4;
  localparam int ANA_EN_BIT = 1;
  localparam int CORE_EN_BIT = 0;
  localparam int APPLY_BIT = 6;
  localparam int STATE_LSB = 16;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [31:0] WAKE_WR_MASK = 32'h001F4331;
  localparam logic [31:0] AWAKE_WR_MASK = 32'h00004331;
  localparam logic [31:0] WAKE1_RST = 32'h00100020;
  localparam logic [31:0] WAKE2_RST = 32'h00100033;
  localparam logic [31:0] AWAKE_RST = 32'h00000033;
  localparam logic [31:0] DWELL_SAT = 32'hFFFFFFFF;

  // ----------------------------------------
  // Sequencer state codes as seen by software
  // ----------------------------------------
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [2:0] CODE_ASLEEP = 3'h1;
  localparam logic [2:0] CODE_WAKE1 = 3'h2;
  localparam logic [2:0] CODE_WAKE2 = 3'h3;
  localparam logic [2:0] CODE_AWAKE_WAIT = 3'h4;
  localparam logic [2:0] CODE_AWAKE = 3'h5;

  // One-hot sequencer states
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_ASLEEP = 6'h02,
    ST_WAKE1 = 6'h04,
    ST_WAKE2 = 6'h08,
    ST_AWAKE_WAIT = 6'h10,
    ST_AWAKE = 6'h20
  } wasc_state_e;

  // Controls driven to the supplies and the tile clock
  typedef struct packed {
    logic tile_clk_gate;
    logic analogue_pfm;
    logic core_pfm;
    logic io_en;
    logic pll_en;
    logic analogue_en;
    logic core_en;
  } wasc_supply_s;

  // Power-good reports from the supplies
  typedef struct packed {
    logic io_good;
    logic pll_good;
    logic analogue_good;
    logic core_good;
  } wasc_good_s;

endpackage

// >>> rtl/wasc_top.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module wasc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sequence requests
  input wire logic wake_req,
  input wire logic sleep_req,
  // Supply interface
  input wire wasc_pkg::wasc_good_s supply_good,
  output wasc_pkg::wasc_supply_s supply_ctl
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Status at 0x24 is the highest offset, so fewer than six bits cannot reach it
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 6 and 8");
  end

  // Control bits, bar the analogue enable, that the supply mapping reads from every state register
  localparam logic [31:0] CTL_WR_BITS = (32'h00000001 << wasc_pkg::TILE_GATE_BIT) |
    (32'h00000001 << wasc_pkg::ANA_PFM_BIT) |
    (32'h00000001 << wasc_pkg::CORE_PFM_BIT) |
    (32'h00000001 << wasc_pkg::IO_EN_BIT) |
    (32'h00000001 << wasc_pkg::PLL_EN_BIT) |
    (32'h00000001 << wasc_pkg::CORE_EN_BIT);
  // The analogue enable reads back but never takes a write
  localparam logic [31:0] ANA_RO_BIT = 32'h00000001 << wasc_pkg::ANA_EN_BIT;
  // Every bit of the dwell exponent
  localparam logic [31:0] DWELL_BITS = ((32'h00000001 << wasc_pkg::DWELL_W) - 32'h00000001) << wasc_pkg::DWELL_LSB;

  // The dwell field must be five bits and fit inside the word
  if (wasc_pkg::DWELL_W != 5 || wasc_pkg::DWELL_LSB + wasc_pkg::DWELL_W > 32) begin : g_bad_dwell
    $error("Dwell field must be five bits inside the word");
  end

  // The waking stages must be able to program every dwell bit
  if ((wasc_pkg::WAKE_WR_MASK & DWELL_BITS) != DWELL_BITS) begin : g_bad_wake
    $error("Dwell field must be writable in the waking stages");
  end

  // The awake register has no dwell field, so its mask stays clear of it
  if ((wasc_pkg::AWAKE_WR_MASK & DWELL_BITS) != 32'h00000000) begin : g_bad_awake
    $error("Awake register must not carry a dwell field");
  end

  // Software must never reach the read-only analogue enable
  if (((wasc_pkg::WAKE_WR_MASK | wasc_pkg::AWAKE_WR_MASK) & ANA_RO_BIT) != 32'h00000000) begin : g_bad_ana
    $error("Analogue enable must stay read-only");
  end

  // Every applied control except the read-only analogue enable must be writable in all three registers
  if ((wasc_pkg::WAKE_WR_MASK & wasc_pkg::AWAKE_WR_MASK & CTL_WR_BITS) != CTL_WR_BITS) begin : g_bad_ctl
    $error("A supply control bit is not writable");
  end

  // The apply strobe is decoded from byte lane 0 only
  if (wasc_pkg::APPLY_BIT > 7) begin : g_bad_apply
    $error("Apply bit must sit in byte lane 0");
  end

  // The status field must hold a three-bit code inside the word
  if (wasc_pkg::STATE_LSB + 3 > 32) begin : g_bad_status
    $error("State field lies outside the status word");
  end

  // Reserved bits read zero from reset, since writes can never clear them
  if ((wasc_pkg::WAKE1_RST & ~(wasc_pkg::WAKE_WR_MASK | ANA_RO_BIT)) != 32'h00000000) begin : g_bad_rst1
    $error("Stage one reset value sets a reserved bit");
  end

  // Same for the second waking stage
  if ((wasc_pkg::WAKE2_RST & ~(wasc_pkg::WAKE_WR_MASK | ANA_RO_BIT)) != 32'h00000000) begin : g_bad_rst2
    $error("Stage two reset value sets a reserved bit");
  end

  // Same for the awake register
  if ((wasc_pkg::AWAKE_RST & ~(wasc_pkg::AWAKE_WR_MASK | ANA_RO_BIT)) != 32'h00000000) begin : g_bad_rst3
    $error("Awake reset value sets a reserved bit");
  end

  // ----------------------------------------
  // State record
  // ----------------------------------------
  typedef struct packed {
    // Sequencer position and dwell count
    wasc_pkg::wasc_state_e st;
    logic [31:0] dwell_cnt;
    // Software-visible configuration words
    logic [31:0] wake1;
    logic [31:0] wake2;
    logic [31:0] awake;
    // Applied controls and bus reply
    wasc_pkg::wasc_supply_s sup;
    logic ack;
    logic [31:0] rdata;
  } wasc_regs_s;

  wasc_regs_s s_r;
  wasc_regs_s s_nxt;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Byte-lane merge restricted to the writable bits
  // Lane enables widen to bit masks before the writable mask is applied
  function automatic logic [31:0] merge_wr(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wdata & m);
  endfunction

  // Dwell 2^n cycles: last count value is 2^n - 1
  // Exponent 0 gives a limit of 0, so the stage lasts one cycle
  function automatic logic [31:0] dwell_limit(input logic [4:0] e);
    logic [5:0] sh;
    sh = 6'h20 - {1'b0, e};
    return wasc_pkg::DWELL_SAT >> sh;
  endfunction

  // Dwell exponent of a waking-stage register
  function automatic logic [4:0] dwell_of(input logic [31:0] c);
    return c[wasc_pkg::DWELL_LSB +: wasc_pkg::DWELL_W];
  endfunction

  // Supply controls taken from a state register
  function automatic wasc_pkg::wasc_supply_s cfg_to_sup(input logic [31:0] c);
    wasc_pkg::wasc_supply_s r;
    r.tile_clk_gate = c[wasc_pkg::TILE_GATE_BIT];
    r.analogue_pfm = c[wasc_pkg::ANA_PFM_BIT];
    r.core_pfm = c[wasc_pkg::CORE_PFM_BIT];
    r.io_en = c[wasc_pkg::IO_EN_BIT];
    r.pll_en = c[wasc_pkg::PLL_EN_BIT];
    r.analogue_en = c[wasc_pkg::ANA_EN_BIT];
    r.core_en = c[wasc_pkg::CORE_EN_BIT];
    return r;
  endfunction

  // Every enabled supply reports good; disabled ones are ignored
  // A supply switched off in this state cannot hold the sequence
  function automatic logic all_good(
    input wasc_pkg::wasc_supply_s sp,
    input wasc_pkg::wasc_good_s g
  );
    return (~sp.core_en | g.core_good) & (~sp.analogue_en | g.analogue_good) &
           (~sp.pll_en | g.pll_good) & (~sp.io_en | g.io_good);
  endfunction

  // Software view of the one-hot state
  // Sleeping codes 6 and 7 never appear: those stages are not built
  function automatic logic [2:0] state_code(input wasc_pkg::wasc_state_e st);
    logic [2:0] c;
    case (st)
      wasc_pkg::ST_ASLEEP: c = wasc_pkg::CODE_ASLEEP;
      wasc_pkg::ST_WAKE1: c = wasc_pkg::CODE_WAKE1;
      wasc_pkg::ST_WAKE2: c = wasc_pkg::CODE_WAKE2;
      wasc_pkg::ST_AWAKE_WAIT: c = wasc_pkg::CODE_AWAKE_WAIT;
      wasc_pkg::ST_AWAKE: c = wasc_pkg::CODE_AWAKE;
      default: c = wasc_pkg::CODE_RESET;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic apply;
  logic dwell_done;
  logic good;
  logic [7:0] addr;

  always_comb begin
    // Every field holds unless a branch below moves it
    s_nxt = s_r;
    addr = 8'(avs_address);
    // One wait cycle per access keeps the read mux out of the bus path
    acc = (avs_read | avs_write) & ~s_r.ack;
    s_nxt.ack = acc;
    // Writes commit in the answer cycle, at the edge where waitrequest is low
    wr_acc = avs_write & s_r.ack;
    rd_acc = avs_read & acc;
    apply = 1'b0;

    // Register writes; unmapped writes are dropped
    // Reserved and read-only bits keep their value through the write mask
    if (wr_acc) begin
      case (addr)
        wasc_pkg::OFS_GEN_CTRL: begin
          apply = avs_byteenable[0] & avs_writedata[wasc_pkg::APPLY_BIT];
        end
        wasc_pkg::OFS_WAKE1: begin
          s_nxt.wake1 = merge_wr(s_r.wake1, avs_writedata, avs_byteenable, wasc_pkg::WAKE_WR_MASK);
        end
        wasc_pkg::OFS_WAKE2: begin
          s_nxt.wake2 = merge_wr(s_r.wake2, avs_writedata, avs_byteenable, wasc_pkg::WAKE_WR_MASK);
        end
        wasc_pkg::OFS_AWAKE: begin
          s_nxt.awake = merge_wr(s_r.awake, avs_writedata, avs_byteenable, wasc_pkg::AWAKE_WR_MASK);
        end
        default: begin
        end
      endcase
    end

    // Read data; apply bit and unmapped words read zero
    // Data are captured in the wait cycle and stand until the next read
    if (rd_acc) begin
      case (addr)
        wasc_pkg::OFS_WAKE1: s_nxt.rdata = s_r.wake1;
        wasc_pkg::OFS_WAKE2: s_nxt.rdata = s_r.wake2;
        wasc_pkg::OFS_AWAKE: s_nxt.rdata = s_r.awake;
        wasc_pkg::OFS_STATUS: s_nxt.rdata = 32'(state_code(s_r.st)) << wasc_pkg::STATE_LSB;
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end

    // Dwell counter saturates so a long dwell never wraps
    // Exponent 31 runs the count to 2^31 - 1, within the 32 counter bits
    if (s_r.dwell_cnt != wasc_pkg::DWELL_SAT) begin
      s_nxt.dwell_cnt = s_r.dwell_cnt + 32'h00000001;
    end
    // Power good is judged against the supplies applied now
    good = all_good(s_r.sup, supply_good);
    dwell_done = 1'b0;
    if (s_r.st == wasc_pkg::ST_WAKE1) begin
      dwell_done = s_r.dwell_cnt >= dwell_limit(dwell_of(s_r.wake1));
    end else if (s_r.st == wasc_pkg::ST_WAKE2) begin
      dwell_done = s_r.dwell_cnt >= dwell_limit(dwell_of(s_r.wake2));
    end

    // Sequencer: settings are applied on entry to ST_WAKE1, ST_WAKE2 and ST_AWAKE_WAIT
    // Sleeping stages are not built: sleep leaves the supplies as they are
    case (s_r.st)
      // Idle until a wake request
      wasc_pkg::ST_RESET, wasc_pkg::ST_ASLEEP: begin
        if (wake_req) begin
          s_nxt.st = wasc_pkg::ST_WAKE1;
          s_nxt.sup = cfg_to_sup(s_r.wake1);
          s_nxt.dwell_cnt = 32'h00000000;
        end
      end
      // Stage one: dwell, then all enabled supplies good
      wasc_pkg::ST_WAKE1: begin
        if (dwell_done && good) begin
          s_nxt.st = wasc_pkg::ST_WAKE2;
          s_nxt.sup = cfg_to_sup(s_r.wake2);
          s_nxt.dwell_cnt = 32'h00000000;
        end
      end
      // Stage two: same test, then the awake settings go out
      wasc_pkg::ST_WAKE2: begin
        if (dwell_done && good) begin
          s_nxt.st = wasc_pkg::ST_AWAKE_WAIT;
          s_nxt.sup = cfg_to_sup(s_r.awake);
        end
      end
      // Wait for the awake supplies
      wasc_pkg::ST_AWAKE_WAIT: begin
        // No dwell here; only the awake supplies must settle
        if (good) begin
          s_nxt.st = wasc_pkg::ST_AWAKE;
        end
      end
      // Sleep wins over an apply in the same cycle
      wasc_pkg::ST_AWAKE: begin
        if (sleep_req) begin
          s_nxt.st = wasc_pkg::ST_ASLEEP;
        end else if (apply) begin
          s_nxt.sup = cfg_to_sup(s_r.awake);
        end
      end
      // Illegal codes fall back to reset
      default: begin
        s_nxt.st = wasc_pkg::ST_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Configuration words take their power-on values; supplies stay off until wake
      s_r.st <= wasc_pkg::ST_RESET;
      s_r.dwell_cnt <= 32'h00000000;
      s_r.wake1 <= wasc_pkg::WAKE1_RST;
      s_r.wake2 <= wasc_pkg::WAKE2_RST;
      s_r.awake <= wasc_pkg::AWAKE_RST;
      s_r.sup <= '0;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h00000000;
    end else begin
      // Whole record moves at once
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Combinational, so an access never waits more than one cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
  // Read data come straight from their register
  assign avs_readdata = s_r.rdata;
  // Supply controls come straight from flip-flops
  assign supply_ctl = s_r.sup;

endmodule

// >>> tb/wasc_assertions.sv
`timescale 1ns/100ps
module wasc_assertions #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Sequencer and supplies
  input wire logic wake_req,
  input wire logic sleep_req,
  input wire wasc_pkg::wasc_good_s supply_good,
  input wire wasc_pkg::wasc_supply_s supply_ctl
);
  logic rq;
  logic rdone;
  logic bad;
  // An enabled supply that is not good yet must freeze the sequence
  assign rq = avs_read | avs_write;
  assign rdone = avs_read & ~avs_waitrequest;
  assign bad = |({supply_ctl.io_en, supply_ctl.pll_en, supply_ctl.analogue_en, supply_ctl.core_en} & ~supply_good);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_wait_first: assert property ($rose(rq) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_unmapped_zero: assert property (rdone && !(avs_address inside {8'h10, 8'h14, 8'h18, 8'h24})
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_awake_rsvd: assert property (rdone && avs_address == 8'h18 |-> (avs_readdata & 32'hFFFFBCCC) == 32'h0)
    else $error("awake reserved bits set");
  a_wake_rsvd: assert property (rdone && avs_address inside {8'h10, 8'h14}
    |-> (avs_readdata & 32'hFFE0BCCC) == 32'h0)
    else $error("wake reserved bits set");
  a_ana_fixed: assert property (rdone && avs_address inside {8'h14, 8'h18} |-> avs_readdata[1])
    else $error("analogue enable lost");
  a_state_code: assert property (rdone && avs_address == 8'h24 |-> avs_readdata[18:16] <= 3'h5)
    else $error("bad state code");
  a_good_block: assert property (bad && !wake_req && !(avs_write && avs_address == 8'h00) |=> $stable(supply_ctl))
    else $error("advanced without power good");
  c_write: cover property (avs_write && !avs_waitrequest);
  c_status: cover property (rdone && avs_address == 8'h24);
  c_change: cover property (!$stable(supply_ctl));
endmodule

bind wasc_top wasc_assertions #(.ADDR_W(ADDR_W)) u_wasc_assertions (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .wake_req(wake_req), .sleep_req(sleep_req), .supply_good(supply_good),
  .supply_ctl(supply_ctl));

// >>> tb/wasc_supply_model.sv
`timescale 1ns/100ps
module wasc_supply_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Stall from the bench: every good stays low
  input wire logic hold,
  // Controls in, reports out
  input wire wasc_pkg::wasc_supply_s ctl,
  output wasc_pkg::wasc_good_s good
);
  logic [3:0] en_r;
  // Good lags the enable by two cycles, so no supply is good at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 4'h0;
      good <= '0;
    end else begin
      en_r <= {ctl.io_en, ctl.pll_en, ctl.analogue_en, ctl.core_en};
      good <= {ctl.io_en, ctl.pll_en, ctl.analogue_en, ctl.core_en} & en_r & ~{4{hold}};
    end
  end
endmodule

// >>> tb/wasc_top_tb_top.sv
`timescale 1ns/100ps
module wasc_top_tb_top;
  logic clk, resetn, rd, wr, wake, sleep, hold, wreq;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdat, d;
  wasc_pkg::wasc_good_s good;
  wasc_pkg::wasc_supply_s ctl;
  int err_total, n_tests, cyc, n;

  wasc_top u_wasc_top (.clk(clk), .resetn(resetn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .wake_req(wake), .sleep_req(sleep), .supply_good(good), .supply_ctl(ctl));
  wasc_supply_model u_wasc_supply_model (.clk(clk), .resetn(resetn), .hold(hold), .ctl(ctl), .good(good));

  // 50 ns clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task give_verdict;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus access; request held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wd <= v;
    be <= b;
    rd <= ~w;
    wr <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat;
    rd <= 0;
    wr <= 0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0, 4'h0);
    chk("register", e, d);
  endtask

  // Counts cycles while the controls keep one value
  task stay(input logic [6:0] e);
    n = 0;
    while (ctl === e && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask

  task t_reset;
    rchk(8'h10, 32'h00100020);
    rchk(8'h14, 32'h00100033);
    rchk(8'h18, 32'h00000033);
    rchk(8'h24, 32'h00000000);
    rchk(8'h30, 32'h00000000);
  endtask

  task t_access;
    bus(1, 8'h10, 32'hFFFFFFFF, 4'hF);
    rchk(8'h10, 32'h001F4331);
    bus(1, 8'h10, 32'h00000000, 4'h4);
    rchk(8'h10, 32'h00004331);
    bus(1, 8'h14, 32'h00000000, 4'hF);
    rchk(8'h14, 32'h00000002);
    bus(1, 8'h18, 32'hFFFFFFFF, 4'hF);
    rchk(8'h18, 32'h00004333);
    bus(1, 8'h10, 32'h00024020, 4'hF);
    bus(1, 8'h14, 32'h00030331, 4'hF);
    bus(1, 8'h18, 32'h00000031, 4'hF);
    rchk(8'h14, 32'h00030333);
  endtask

  // Wake with goods stalled, then release and time the second stage
  task t_wake;
    hold <= 1;
    @(posedge clk);
    wake <= 1;
    @(posedge clk);
    wake <= 0;
    @(negedge clk);
    chk("controls", 32'h48, 32'(ctl));
    repeat (20) @(negedge clk);
    chk("controls", 32'h48, 32'(ctl));
    rchk(8'h24, 32'h00020000);
    hold <= 0;
    stay(7'h48);
    chk("controls", 32'h3F, 32'(ctl));
    stay(7'h3F);
    chk("dwell", 32'h1, 32'(n >= 8 && n <= 9));
    chk("controls", 32'h0F, 32'(ctl));
    repeat (4) @(negedge clk);
    rchk(8'h24, 32'h00050000);
  endtask

  task t_apply;
    bus(1, 8'h18, 32'h00004331, 4'hF);
    repeat (2) @(negedge clk);
    chk("controls", 32'h0F, 32'(ctl));
    bus(1, 8'h00, 32'h00000040, 4'h1);
    repeat (2) @(negedge clk);
    chk("controls", 32'h7F, 32'(ctl));
    bus(1, 8'h18, 32'h00000020, 4'hF);
    bus(1, 8'h00, 32'h00000040, 4'h1);
    repeat (2) @(negedge clk);
    chk("controls", 32'h0A, 32'(ctl));
  endtask

  task t_sleep;
    @(posedge clk);
    sleep <= 1;
    @(posedge clk);
    sleep <= 0;
    rchk(8'h24, 32'h00010000);
  endtask

  // Main sequence after a 16 cycle reset
  initial begin
    resetn = 0;
    rd = 0;
    wr = 0;
    wake = 0;
    sleep = 0;
    hold = 0;
    addr = 8'h00;
    wd = 32'h0;
    be = 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1;
    t_reset;
    t_access;
    t_wake;
    t_apply;
    t_sleep;
    give_verdict;
  end

  // Hang guard, well above the 130 or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict;
    end
  end
endmodule
